//--- sim/serial_far_end.sv
`timescale 1ns/1ps
module serial_far_end
(
  input  wire logic        drive_i,
  input  wire logic        tdm_i,
  input  wire logic        bclk_i,
  input  wire logic        frame_i,
  input  wire logic        dout_i,
  input  wire logic [15:0] pat0_i,
  input  wire logic [15:0] pat1_i,
  output logic             clk_o,
  output logic             frame_o,
  output logic             din_o,
  output logic [15:0]      got0_o,
  output logic [15:0]      got1_o
);
  logic [4:0] cnt;
  logic [4:0] n;
  logic       prev;
  logic       sync;

  initial
  begin
    clk_o = 1'b0; // low while in reset
    {frame_o, din_o, prev, sync, cnt, got0_o, got1_o} = '0;
    forever
    begin
      #62.5;
      clk_o = drive_i ? ~clk_o : 1'b0; // runs only as master
    end
  end

  always @(posedge bclk_i)
  begin
    sync <= tdm_i ? frame_i : (prev & ~frame_i);
    prev <= frame_i;
    if (cnt[4])
      got1_o[~cnt[3:0]] <= dout_i;
    else
      got0_o[~cnt[3:0]] <= dout_i;
  end

  always @(negedge bclk_i)
  begin
    n = sync ? 5'h00 : cnt + 5'h01;
    cnt <= n;
    frame_o <= tdm_i ? (n == 5'h1F) : (n >= 5'h0F && n <= 5'h1E);
    din_o <= n[4] ? pat1_i[~n[3:0]] : pat0_i[~n[3:0]]; // msb first
  end
endmodule

//--- sim/tdm_i2s_serial_port_bench.sv
`timescale 1ns/1ps
module tdm_i2s_serial_port_bench;
  import tdm_i2s_pkg::*;
  localparam logic [15:0] W = 16'hC3A5;
  localparam logic [15:0] P0 = 16'h8D21;
  localparam logic [15:0] P1 = 16'h4EB7;
  logic        mclk, reset_n, cfg_load, cfg_tdm, cfg_master, tx_valid, tx_ready;
  logic        mode_tdm, mode_master, rx_valid, aligned, rx_slot, far_drive, far_tdm;
  logic        bclk_o, bclk_oe, fr_o, fr_oe, din, dout, far_clk, far_fr, bclk, fr;
  logic [15:0] tx_word, rx_word, got0, got1;
  int          mismatches;
  int          n_compared;

  assign bclk = bclk_oe ? bclk_o : far_clk;
  assign fr = fr_oe ? fr_o : far_fr;

  tdm_i2s_serial_port #(.WORD_W(16), .SLOTS(2)) uut
  (
    .mclk_i(mclk), .reset_n_i(reset_n), .cfg_load_i(cfg_load), .cfg_tdm_i(cfg_tdm),
    .cfg_master_i(cfg_master), .mode_tdm_o(mode_tdm), .mode_master_o(mode_master),
    .tx_word_i(tx_word), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .rx_word_o(rx_word), .rx_slot_o(rx_slot), .rx_valid_o(rx_valid),
    .frame_aligned_o(aligned), .port_a_bit_clock_i(bclk), .port_a_bit_clock_o(bclk_o),
    .port_a_bit_clock_oe_o(bclk_oe), .port_a_frame_pulse_i(fr),
    .port_a_frame_pulse_o(fr_o), .port_a_frame_pulse_oe_o(fr_oe),
    .port_a_serial_in_i(din), .port_a_serial_out_o(dout)
  );

  serial_far_end far
  (
    .drive_i(far_drive), .tdm_i(far_tdm), .bclk_i(bclk), .frame_i(fr), .dout_i(dout),
    .pat0_i(P0), .pat1_i(P1), .clk_o(far_clk), .frame_o(far_fr), .din_o(din),
    .got0_o(got0), .got1_o(got1)
  );

  task automatic check1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s %h", $time, what, got);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic rx_wait();
    int k;
    k = 0;
    do
    begin
      @(posedge mclk);
      #1;
      k++;
    end while (rx_valid !== 1'b1 && k < 2000);
    check1(rx_valid, 1'b1, "no word");
  endtask

  task automatic t_reset();
    #1;
    check1(mode_tdm, 1'b0, "reset kind");
    check1(mode_master, 1'b0, "reset role");
    check1(bclk_oe, 1'b0, "reset clock pin");
    check1(fr_oe, 1'b0, "reset frame pin");
    check1(tx_ready, 1'b1, "reset ready");
  endtask

  task automatic t_mode(input logic tdm, input logic mst);
    int   k;
    logic s;
    @(posedge mclk);
    tx_valid <= 1'b1;
    tx_word <= W ^ {14'h0000, tdm, mst};
    far_drive <= ~mst;
    far_tdm <= tdm;
    cfg_tdm <= tdm;
    cfg_master <= mst;
    cfg_load <= 1'b1;
    @(posedge mclk);
    cfg_load <= 1'b0;
    @(posedge mclk);
    #1;
    check1(mode_tdm, tdm, "mode kind");
    check1(mode_master, mst, "mode role");
    @(posedge mclk);
    #1;
    check1(bclk_oe, mst, "clock pin drive");
    check1(fr_oe, mst, "frame pin drive");
    repeat (64) @(posedge mclk);
    #1;
    k = 0;
    while (aligned !== 1'b1 && k < 3000)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    check1(aligned, 1'b1, "no lock");
    repeat (6) rx_wait();
    rx_wait();
    s = rx_slot;
    check16(rx_word, s ? P1 : P0, "received word");
    rx_wait();
    check1(rx_slot, ~s, "slot order");
    check16(rx_word, s ? P0 : P1, "received word");
    check16(got0, W ^ {14'h0000, tdm, mst}, "sent slot 0");
    check16(got1, W ^ {14'h0000, tdm, mst}, "sent slot 1");
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    #400000;
    mismatches++;
    conclude();
  end

  initial
  begin
    {cfg_load, cfg_tdm, cfg_master, tx_valid, far_drive, far_tdm} = '0;
    reset_n <= 1'b0;
    tx_word = W;
    mismatches = 0;
    n_compared = 0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_mode(1'b1, 1'b1);
    t_mode(1'b1, 1'b0);
    t_mode(1'b0, 1'b1);
    t_mode(1'b0, 1'b0);
    conclude();
  end
endmodule

//--- sim/tdm_i2s_serial_port_chk.sv
`timescale 1ns/1ps
module tdm_i2s_serial_port_chk
#(
  parameter int WORD_W = 16,
  parameter int SLOTS  = 2
)
(
  input  wire logic                     mclk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     cfg_load_i,
  input  wire logic                     cfg_tdm_i,
  input  wire logic                     cfg_master_i,
  input  wire logic                     mode_tdm_o,
  input  wire logic                     mode_master_o,
  input  wire logic                     tx_valid_i,
  input  wire logic                     tx_ready_o,
  input  wire logic [WORD_W-1:0]        rx_word_o,
  input  wire logic [$clog2(SLOTS)-1:0] rx_slot_o,
  input  wire logic                     rx_valid_o,
  input  wire logic                     frame_aligned_o,
  input  wire logic                     port_a_bit_clock_o,
  input  wire logic                     port_a_bit_clock_oe_o,
  input  wire logic                     port_a_frame_pulse_oe_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  AST_CFG_MODE:
  assert property (cfg_load_i |=> mode_tdm_o == $past(cfg_tdm_i)
    && mode_master_o == $past(cfg_master_i)) else $error("mode not loaded");
  AST_OE_FOLLOW:
  assert property (cfg_load_i |-> ##2 port_a_bit_clock_oe_o == $past(cfg_master_i, 2))
    else $error("clock drive late");
  AST_MODE_HOLD:
  assert property (!cfg_load_i |=> $stable(mode_tdm_o) && $stable(mode_master_o))
    else $error("mode moved");
  AST_OE_PAIR:
  assert property (port_a_bit_clock_oe_o == port_a_frame_pulse_oe_o)
    else $error("frame drive differs");
  AST_SLAVE_IDLE:
  assert property (!mode_master_o [*8] |-> !port_a_bit_clock_o)
    else $error("clock out in slave");
  AST_BCLK_HALF:
  assert property (disable iff (!reset_n_i || !mode_master_o)
    $rose(port_a_bit_clock_o) |-> port_a_bit_clock_o [*8] ##1 !port_a_bit_clock_o)
    else $error("bad half period");
  AST_TX_TAKE:
  assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o) else $error("ready stuck");
  AST_RX_PULSE:
  assert property (rx_valid_o |=> !rx_valid_o) else $error("long rx pulse");
  AST_RX_HOLD:
  assert property (!rx_valid_o |-> $stable(rx_word_o) && $stable(rx_slot_o))
    else $error("rx moved");

  cover property (cfg_load_i && cfg_tdm_i && cfg_master_i);
  cover property (rx_valid_o && rx_slot_o != '0);
  cover property ($rose(frame_aligned_o));
endmodule

bind tdm_i2s_serial_port tdm_i2s_serial_port_chk #(.WORD_W(WORD_W), .SLOTS(SLOTS)) chk
(
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .cfg_load_i(cfg_load_i),
  .cfg_tdm_i(cfg_tdm_i), .cfg_master_i(cfg_master_i), .mode_tdm_o(mode_tdm_o),
  .mode_master_o(mode_master_o), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
  .rx_word_o(rx_word_o), .rx_slot_o(rx_slot_o), .rx_valid_o(rx_valid_o),
  .frame_aligned_o(frame_aligned_o), .port_a_bit_clock_o(port_a_bit_clock_o),
  .port_a_bit_clock_oe_o(port_a_bit_clock_oe_o),
  .port_a_frame_pulse_oe_o(port_a_frame_pulse_oe_o)
);

//--- src/port_link_engine.sv
`timescale 1ns/1ps
module port_link_engine
#(
  parameter int WORD_W = tdm_i2s_pkg::WORD_W_DEF,
  parameter int SLOTS  = tdm_i2s_pkg::SLOTS_DEF
)
(
  input  wire logic                     link_clk_i,
  input  wire logic                     link_rst_n_i,
  input  wire logic                     cfg_tdm_i,
  input  wire logic                     cfg_master_i,
  input  wire logic                     serial_in_i,
  input  wire logic                     frame_in_i,
  input  wire logic [WORD_W-1:0]        tx_word_i,
  input  wire logic                     tx_req_i,
  output logic                          tx_ack_o,
  output logic [WORD_W-1:0]             rx_word_o,
  output logic [$clog2(SLOTS)-1:0]      rx_slot_o,
  output logic                          rx_tog_o,
  output logic                          aligned_o,
  output logic                          serial_out_o,
  output logic                          frame_out_o
);
  import tdm_i2s_pkg::*;

  localparam int PW    = $clog2(WORD_W);
  localparam int SW    = $clog2(SLOTS);
  localparam int CNT_W = PW + SW;
  localparam logic [PW-1:0] POS_LAST = PW'(WORD_W - 1);

  typedef struct packed {
    logic [1:0]        cfg_s1;
    logic [1:0]        cfg_s2;
    logic              req_s1;
    logic              req_s2;
    logic              ack;
    logic              ws_prev;
    align_e            align;
    logic [CNT_W-1:0]  cnt;
    logic [WORD_W-1:0] tx_shift;
    logic [WORD_W-1:0] rx_shift;
    logic [WORD_W-1:0] rx_word;
    logic [SW-1:0]     rx_slot;
    logic              rx_tog;
    logic              sout;
    logic              fout;
  } eng_s;

  eng_s eng_reg;
  eng_s eng_next;

  always_comb
  begin
    logic             tdm;
    logic             master;
    logic             realign;
    logic [CNT_W-1:0] cnt_inc;
    logic [CNT_W-1:0] cnt_n;
    logic [CNT_W-1:0] cnt_n1;
    logic [WORD_W-1:0] word;
    tdm      = 1'b0;
    master   = 1'b0;
    realign  = 1'b0;
    cnt_inc  = '0;
    cnt_n    = '0;
    cnt_n1   = '0;
    word     = '0;
    eng_next = eng_reg;

    // mode bits cross from the system clock
    eng_next.cfg_s1 = {cfg_tdm_i, cfg_master_i};
    eng_next.cfg_s2 = eng_reg.cfg_s1;
    eng_next.req_s1 = tx_req_i;
    eng_next.req_s2 = eng_reg.req_s1;
    tdm             = eng_reg.cfg_s2[1];
    master          = eng_reg.cfg_s2[0];

    // slave alignment: frame pulse or left word select edge
    eng_next.ws_prev = frame_in_i;
    realign = !master && (tdm ? frame_in_i
                              : (eng_reg.ws_prev && !frame_in_i));
    cnt_inc = eng_reg.cnt + 1'b1;
    cnt_n   = realign ? '0 : cnt_inc;
    eng_next.cnt = cnt_n;

    case (eng_reg.align)
      ALIGN_SEARCH:
      begin
        if (master || realign)
        begin
          eng_next.align = ALIGN_LOCKED;
        end
      end
      ALIGN_LOCKED:
      begin
        // lost frame in slave mode
        if (!master && ((cnt_inc == '0) != realign))
        begin
          eng_next.align = ALIGN_SEARCH;
        end
      end
      default:
      begin
        eng_next.align = ALIGN_SEARCH;
      end
    endcase

    // transmit, one bit per bit clock
    if (cnt_n[PW-1:0] == '0)
    begin
      if ((eng_next.align == ALIGN_LOCKED) && (eng_reg.req_s2 != eng_reg.ack))
      begin
        word         = tx_word_i;
        eng_next.ack = ~eng_reg.ack;
      end
      eng_next.tx_shift = {word[WORD_W-2:0], 1'b0};
      eng_next.sout     = word[WORD_W-1];
    end
    else
    begin
      eng_next.tx_shift = {eng_reg.tx_shift[WORD_W-2:0], 1'b0};
      eng_next.sout     = eng_reg.tx_shift[WORD_W-1];
    end

    // receive, one bit per bit clock
    eng_next.rx_shift = {eng_reg.rx_shift[WORD_W-2:0], serial_in_i};
    if ((eng_reg.cnt[PW-1:0] == POS_LAST) && (eng_reg.align == ALIGN_LOCKED))
    begin
      eng_next.rx_word = {eng_reg.rx_shift[WORD_W-2:0], serial_in_i};
      eng_next.rx_slot = eng_reg.cnt[CNT_W-1:PW];
      eng_next.rx_tog  = ~eng_reg.rx_tog;
    end

    // master frame: pulse on last bit, word select leads msb by one bit
    cnt_n1 = cnt_n + 1'b1;
    if (!master)
    begin
      eng_next.fout = 1'b0;
    end
    else if (tdm)
    begin
      eng_next.fout = &cnt_n;
    end
    else
    begin
      eng_next.fout = |cnt_n1[CNT_W-1:PW];
    end
  end

  // falling edge launch; bit clock held low in reset
  always_ff @(negedge link_clk_i or negedge link_rst_n_i)
  begin
    if (!link_rst_n_i)
    begin
      eng_reg <= '{cfg_s1: RST_LINK_SYNC, cfg_s2: RST_LINK_SYNC, align: ALIGN_SEARCH,
                   default: '0};
    end
    else
    begin
      eng_reg <= eng_next;
    end
  end

  assign tx_ack_o     = eng_reg.ack;
  assign rx_word_o    = eng_reg.rx_word;
  assign rx_slot_o    = eng_reg.rx_slot;
  assign rx_tog_o     = eng_reg.rx_tog;
  assign aligned_o    = (eng_reg.align == ALIGN_LOCKED);
  assign serial_out_o = eng_reg.sout;
  assign frame_out_o  = eng_reg.fout;

endmodule

//--- src/port_link_front.sv
`timescale 1ns/1ps
module port_link_front
(
  input  wire logic link_clk_i,
  input  wire logic reset_n_i,
  input  wire logic serial_in_i,
  input  wire logic frame_in_i,
  output logic      link_rst_n_o,
  output logic      serial_in_o,
  output logic      frame_in_o
);
  import tdm_i2s_pkg::*;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic       din;
    logic       fin;
  } front_s;

  front_s front_reg;
  front_s front_next;

  always_comb
  begin
    front_next          = front_reg;
    front_next.rst_sync = {front_reg.rst_sync[0], 1'b1};
    front_next.din      = serial_in_i;
    front_next.fin      = frame_in_i;
  end

  // rising edge capture, half a bit ahead of the falling edge engine
  always_ff @(posedge link_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      front_reg <= '{rst_sync: RST_LINK_SYNC, din: 1'b0, fin: 1'b0};
    end
    else
    begin
      front_reg <= front_next;
    end
  end

  assign link_rst_n_o = front_reg.rst_sync[1];
  assign serial_in_o  = front_reg.din;
  assign frame_in_o   = front_reg.fin;

endmodule

//--- src/tdm_i2s_pkg.sv
package tdm_i2s_pkg;

  // serial framing defaults
  localparam int WORD_W_DEF    = 16;
  localparam int SLOTS_DEF     = 2;

  // master bit clock timing
  localparam int MCLK_PERIOD_NS = 8;
  localparam int BCLK_HALF_NS   = 64;
  localparam int BCLK_HALF_CYC  = (BCLK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int DIV_W          = 8;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_HALF_CYC - 1);

  // reset values
  localparam logic       RST_MODE_TDM    = 1'b0;
  localparam logic       RST_MODE_MASTER = 1'b0;
  localparam logic       RST_TX_READY    = 1'b1;
  localparam logic [1:0] RST_LINK_SYNC   = 2'b00;

  typedef enum logic [1:0]
  {
    ALIGN_SEARCH = 2'b01,
    ALIGN_LOCKED = 2'b10
  } align_e;

endpackage

//--- src/tdm_i2s_serial_port.sv
`timescale 1ns/1ps
// What this block does
// - each port separately master or slave
// - pcm time division or stereo, shared pins
// - framing follows standard pcm and stereo timing
// - one bit clock period per data bit
// - time division master drives clock, slave receives it
// - stereo master drives clock, slave receives it
// - reset: clock and frame pins inputs, slave
// - frame pin is time division alignment pulse
// - frame pin is stereo left/right select
// - serial input sampled each bit clock
// - serial output launched each bit clock
module tdm_i2s_serial_port
#(
  parameter int WORD_W = tdm_i2s_pkg::WORD_W_DEF,
  parameter int SLOTS  = tdm_i2s_pkg::SLOTS_DEF
)
(
  input  wire logic                     mclk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     cfg_load_i,
  input  wire logic                     cfg_tdm_i,
  input  wire logic                     cfg_master_i,
  output logic                          mode_tdm_o,
  output logic                          mode_master_o,
  input  wire logic [WORD_W-1:0]        tx_word_i,
  input  wire logic                     tx_valid_i,
  output logic                          tx_ready_o,
  output logic [WORD_W-1:0]             rx_word_o,
  output logic [$clog2(SLOTS)-1:0]      rx_slot_o,
  output logic                          rx_valid_o,
  output logic                          frame_aligned_o,
  input  wire logic                     port_a_bit_clock_i,
  output logic                          port_a_bit_clock_o,
  output logic                          port_a_bit_clock_oe_o,
  input  wire logic                     port_a_frame_pulse_i,
  output logic                          port_a_frame_pulse_o,
  output logic                          port_a_frame_pulse_oe_o,
  input  wire logic                     port_a_serial_in_i,
  output logic                          port_a_serial_out_o
);
  import tdm_i2s_pkg::*;

  localparam int SW = $clog2(SLOTS);

  typedef struct packed {
    logic              cfg_tdm;
    logic              cfg_master;
    logic              clk_oe;
    logic              frame_oe;
    logic [DIV_W-1:0]  div_cnt;
    logic              bclk;
    logic [WORD_W-1:0] tx_hold;
    logic              tx_ready;
    logic              tx_req;
    logic              ack_s1;
    logic              ack_s2;
    logic              ack_seen;
    logic              rx_s1;
    logic              rx_s2;
    logic              rx_seen;
    logic [WORD_W-1:0] rx_word;
    logic [SW-1:0]     rx_slot;
    logic              rx_valid;
    logic              al_s1;
    logic              al_s2;
  } port_s;

  port_s port_reg;
  port_s port_next;

  logic              link_rst_n;
  logic              link_din;
  logic              link_fin;
  logic              link_ack;
  logic [WORD_W-1:0] link_rx_word;
  logic [SW-1:0]     link_rx_slot;
  logic              link_rx_tog;
  logic              link_aligned;
  logic              link_sout;
  logic              link_fout;

  port_link_front u_front
  (
    .link_clk_i   (port_a_bit_clock_i),
    .reset_n_i    (reset_n_i),
    .serial_in_i  (port_a_serial_in_i),
    .frame_in_i   (port_a_frame_pulse_i),
    .link_rst_n_o (link_rst_n),
    .serial_in_o  (link_din),
    .frame_in_o   (link_fin)
  );

  port_link_engine #(
    .WORD_W (WORD_W),
    .SLOTS  (SLOTS)
  ) u_engine
  (
    .link_clk_i   (port_a_bit_clock_i),
    .link_rst_n_i (link_rst_n),
    .cfg_tdm_i    (port_reg.cfg_tdm),
    .cfg_master_i (port_reg.cfg_master),
    .serial_in_i  (link_din),
    .frame_in_i   (link_fin),
    .tx_word_i    (port_reg.tx_hold),
    .tx_req_i     (port_reg.tx_req),
    .tx_ack_o     (link_ack),
    .rx_word_o    (link_rx_word),
    .rx_slot_o    (link_rx_slot),
    .rx_tog_o     (link_rx_tog),
    .aligned_o    (link_aligned),
    .serial_out_o (link_sout),
    .frame_out_o  (link_fout)
  );

  always_comb
  begin
    port_next = port_reg;

    // mode held until software loads a new one
    if (cfg_load_i)
    begin
      port_next.cfg_tdm    = cfg_tdm_i;
      port_next.cfg_master = cfg_master_i;
    end

    // pin directions follow the held mode only
    port_next.clk_oe   = port_reg.cfg_master;
    port_next.frame_oe = port_reg.cfg_master;

    // master bit clock from the system clock
    if (port_reg.cfg_master)
    begin
      if (port_reg.div_cnt == DIV_LAST)
      begin
        port_next.div_cnt = '0;
        port_next.bclk    = ~port_reg.bclk;
      end
      else
      begin
        port_next.div_cnt = port_reg.div_cnt + 1'b1;
      end
    end
    else
    begin
      port_next.div_cnt = '0;
      port_next.bclk    = 1'b0;
    end

    // transmit word handshake toward the link
    port_next.ack_s1   = link_ack;
    port_next.ack_s2   = port_reg.ack_s1;
    port_next.ack_seen = port_reg.ack_s2;
    if (tx_valid_i && port_reg.tx_ready)
    begin
      port_next.tx_hold  = tx_word_i;
      port_next.tx_ready = 1'b0;
      port_next.tx_req   = ~port_reg.tx_req;
    end
    else if (port_reg.ack_s2 != port_reg.ack_seen)
    begin
      port_next.tx_ready = 1'b1;
    end

    // receive word handshake from the link
    port_next.rx_s1   = link_rx_tog;
    port_next.rx_s2   = port_reg.rx_s1;
    port_next.rx_seen = port_reg.rx_s2;
    port_next.rx_valid = 1'b0;
    if (port_reg.rx_s2 != port_reg.rx_seen)
    begin
      port_next.rx_word  = link_rx_word;
      port_next.rx_slot  = link_rx_slot;
      port_next.rx_valid = 1'b1;
    end

    port_next.al_s1 = link_aligned;
    port_next.al_s2 = port_reg.al_s1;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      // slave stereo, clock and frame pins as inputs
      port_reg <= '{cfg_tdm: RST_MODE_TDM, cfg_master: RST_MODE_MASTER,
                    tx_ready: RST_TX_READY, default: '0};
    end
    else
    begin
      port_reg <= port_next;
    end
  end

  assign mode_tdm_o              = port_reg.cfg_tdm;
  assign mode_master_o           = port_reg.cfg_master;
  assign tx_ready_o              = port_reg.tx_ready;
  assign rx_word_o               = port_reg.rx_word;
  assign rx_slot_o               = port_reg.rx_slot;
  assign rx_valid_o              = port_reg.rx_valid;
  assign frame_aligned_o         = port_reg.al_s2;
  assign port_a_bit_clock_o      = port_reg.bclk;
  assign port_a_bit_clock_oe_o   = port_reg.clk_oe;
  assign port_a_frame_pulse_o    = link_fout;
  assign port_a_frame_pulse_oe_o = port_reg.frame_oe;
  assign port_a_serial_out_o     = link_sout;

endmodule
